// *** hbc_ahb_slave.sv ***
`timescale 1ns/1ps
// AHB-Lite slave front end that turns bus transfers into one-cycle register strobes.
module hbc_ahb_slave (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             wr_strobe,
   output logic             rd_strobe,
   output logic [31:0]      reg_addr,
   output logic [31:0]      reg_wdata
);

   logic pend_wr;
   logic pend_rd;

   // Zero wait states: the data phase always completes in its first cycle.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_wr  <= 1'b0;
         pend_rd  <= 1'b0;
         reg_addr <= 32'h0000_0000;
      end else begin
         pend_wr <= hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
         pend_rd <= hsel && hready && htrans[1] && !hwrite;
         if (hsel && hready && htrans[1]) begin
            reg_addr <= haddr;
         end
      end
   end

   assign wr_strobe = pend_wr;
   assign rd_strobe = pend_rd;
   assign reg_wdata = hwdata;

endmodule : hbc_ahb_slave

// *** hbc_byte_cmp.sv ***
`timescale 1ns/1ps
// One 16-bit compare with an optional low byte and high byte, as used by every breakpoint.
module hbc_byte_cmp (
   input  wire logic [15:0] ref_value,
   input  wire logic [15:0] bus_value,
   input  wire logic        use_high,
   input  wire logic        use_low,
   output logic             match
);

   assign match = (!use_high || (ref_value[15:8] == bus_value[15:8]))
                  && (!use_low || (ref_value[7:0] == bus_value[7:0]));

endmodule : hbc_byte_cmp

// *** hbc_cpu_model.sv ***
`timescale 1ns/1ps
// Behavioural model of the CPU bus side that the comparator watches.
module hbc_cpu_model (
   input  wire logic  hclk,
   input  wire logic  fetch_tag,
   output logic        cpu_cycle_valid,
   output logic [15:0] cpu_addr,
   output logic [15:0] cpu_data,
   output logic        cpu_read,
   output logic        cpu_fetch,
   output logic        cpu_exec_valid,
   output logic        cpu_exec_tag,
   output logic        cpu_boundary
);
   initial begin
      {cpu_cycle_valid, cpu_read, cpu_fetch, cpu_exec_valid, cpu_exec_tag, cpu_boundary} = 6'h00;
      cpu_addr = 16'h0000;
      cpu_data = 16'h0000;
   end

   // Idle buses carry the inverse so a stale value can never look like a match.
   task cycle(input logic [15:0] a, input logic [15:0] d, input logic rd, input logic f,
              output logic tag);
      cpu_cycle_valid <= 1'b1;
      cpu_addr        <= a;
      cpu_data        <= d;
      cpu_read        <= rd;
      cpu_fetch       <= f;
      @(posedge hclk);
      tag = fetch_tag;
      cpu_cycle_valid <= 1'b0;
      cpu_addr        <= ~a;
      cpu_data        <= ~d;
      cpu_fetch       <= 1'b0;
   endtask : cycle

   task execute(input logic tag);
      cpu_exec_valid <= 1'b1;
      cpu_exec_tag   <= tag;
      @(posedge hclk);
      cpu_exec_valid <= 1'b0;
      cpu_exec_tag   <= 1'b0;
   endtask : execute

   task boundary();
      cpu_boundary <= 1'b1;
      @(posedge hclk);
      cpu_boundary <= 1'b0;
   endtask : boundary
endmodule : hbc_cpu_model

// *** hbc_pkg.sv ***
// Package with register map, field positions and modes of the breakpoint comparator.
package hbc_pkg;

   localparam logic [31:0] ctl1_addr      = 32'h0000_0021;
   localparam logic [31:0] ctl1_byte_addr = ctl1_addr << 2;
   // Every register owns one word, so no two may share a byte address.
   localparam logic [31:0] ctl0_byte_addr = 32'h0000_0080;
   localparam logic [31:0] addr_byte_addr = 32'h0000_0088;
   localparam logic [31:0] data_byte_addr = 32'h0000_008c;
   localparam logic [31:0] stat_byte_addr = 32'h0000_0090;

   // Control register zero fields.
   localparam int ctl0_mode_hi_pos    = 7;
   localparam int ctl0_mode_lo_pos    = 6;
   localparam int ctl0_prog_only_pos  = 5;
   localparam int ctl0_range1_pos     = 1;
   localparam int ctl0_range0_pos     = 0;
   // Control register one fields.
   localparam int ctl1_data_en_pos    = 7;
   localparam int ctl1_mask_hi_pos    = 6;
   localparam int ctl1_mask_lo_pos    = 5;
   localparam int ctl1_rw1_en_pos     = 4;
   localparam int ctl1_rw1_val_pos    = 3;
   localparam int ctl1_rw0_en_pos     = 2;
   localparam int ctl1_rw0_val_pos    = 1;

   localparam logic [7:0]  ctl0_reset     = 8'h00;
   localparam logic [7:0]  ctl1_reset     = 8'h00;
   localparam logic [7:0]  ctl0_wmask     = 8'he3;
   localparam logic [7:0]  ctl1_wmask     = 8'hfe;
   localparam logic [15:0] bkreg_reset    = 16'h0000;

   typedef enum logic [1:0] {
      hbc_mode_off,
      hbc_mode_irq_dual,
      hbc_mode_halt_full,
      hbc_mode_halt_dual
   } hbc_mode_t;

endpackage : hbc_pkg

// *** hbc_top.sv ***
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Hardware breakpoint comparator with its AHB-Lite register file.
// How it works
// - Two mode bits pick off, dual interrupt, full halt or dual halt.
// - No match counts while the debug mode is already active.
// - Only dual interrupt mode raises interrupts; it tags fetches, no data compare.
// - Dual interrupt mode ignores read/write and mask bits; ranges still apply.
// - In dual modes the data enable bit enables the second address breakpoint.
// - Full mode ignores second range and second read/write bits.
// - Full mode data enable and masks work only when program-only is clear.
// - Dual halt mode ignores masks; program-only also drops read/write bits.
// - Halt requests need the debug enable indication from the debug unit.
// - Address registers meet the address bus; data registers meet data or address.
// - Program-only clear breaks at boundary; set breaks only on executed tagged opcode.
// - Program-only has no effect in dual interrupt mode, always program breaks.
// - Second range bit clear compares upper address byte, set full address.
// - First range bit clear compares upper address byte, set full address.
// - Data enable clear removes data registers from every compare.
// - High mask clear compares data bits 15:8; set excludes them.
// - Low mask clear compares data bits 7:0; set excludes them.
// - Second read/write enable qualifies second breakpoint only in dual data-only cases.
// - Second read/write value: clear matches writes, set matches reads.
// - First read/write enable includes read/write in the first breakpoint match.
// - Both control registers are readable and writable at any time.
// - First read/write value: clear matches writes, set matches reads.
module hbc_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        cpu_cycle_valid,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [15:0] cpu_data,
   input  wire logic        cpu_read,
   input  wire logic        cpu_fetch,
   input  wire logic        cpu_exec_valid,
   input  wire logic        cpu_exec_tag,
   input  wire logic        cpu_boundary,
   input  wire logic        debug_halt_mode_active,
   input  wire logic        debug_halt_mode_enabled,
   output logic             fetch_tag,
   output logic             software_interrupt_req,
   output logic             debug_halt_mode_req
);

   logic [7:0]           breakpoint_control_zero;
   logic [7:0]           breakpoint_control_one;
   logic [7:0]           break_addr_high;
   logic [7:0]           break_addr_low;
   logic [7:0]           break_data_high;
   logic [7:0]           break_data_low;
   logic                 wr_strobe;
   logic [31:0]          reg_addr;
   logic [31:0]          reg_wdata;
   hbc_pkg::hbc_mode_t   mode;
   logic                 program_only_break;
   logic                 second_range_full;
   logic                 first_range_full;
   logic                 data_reg_compare_enable;
   logic                 high_byte_mask;
   logic                 low_byte_mask;
   logic                 second_rw_qualify_enable;
   logic                 second_rw_value;
   logic                 first_rw_qualify_enable;
   logic                 first_rw_value;
   logic                 prog_mode;
   logic                 bp0_addr_hit;
   logic                 bp1_addr_hit;
   logic                 data_hit;
   logic                 bp0_use_rw;
   logic                 bp1_use_rw;
   logic                 bp0_hit;
   logic                 bp1_hit;
   logic                 data_use_high;
   logic                 data_use_low;
   logic                 full_data_on;
   logic                 raw_match;
   logic                 pending_boundary;
   logic                 halt_allowed;

   hbc_ahb_slave u_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .wr_strobe (wr_strobe),
      .rd_strobe (),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata)
   );

   // Register writes; control registers take writes in every mode.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         breakpoint_control_zero <= hbc_pkg::ctl0_reset;
         breakpoint_control_one  <= hbc_pkg::ctl1_reset;
      end else if (wr_strobe) begin
         if (reg_addr == hbc_pkg::ctl0_byte_addr) begin
            breakpoint_control_zero <= reg_wdata[7:0] & hbc_pkg::ctl0_wmask;
         end
         if (reg_addr == hbc_pkg::ctl1_byte_addr) begin
            breakpoint_control_one <= reg_wdata[7:0] & hbc_pkg::ctl1_wmask;
         end
      end
   end

   // The compare value registers are cleared only by the power-on style reset here.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {break_addr_high, break_addr_low} <= hbc_pkg::bkreg_reset;
         {break_data_high, break_data_low} <= hbc_pkg::bkreg_reset;
      end else if (wr_strobe) begin
         if (reg_addr == hbc_pkg::addr_byte_addr) begin
            {break_addr_high, break_addr_low} <= reg_wdata[15:0];
         end
         if (reg_addr == hbc_pkg::data_byte_addr) begin
            {break_data_high, break_data_low} <= reg_wdata[15:0];
         end
      end
   end

   // Read data is registered at the address phase so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr)
            hbc_pkg::ctl0_byte_addr: hrdata <= {24'h000000, breakpoint_control_zero};
            hbc_pkg::ctl1_byte_addr: hrdata <= {24'h000000, breakpoint_control_one};
            hbc_pkg::addr_byte_addr: hrdata <= {16'h0000, break_addr_high, break_addr_low};
            hbc_pkg::data_byte_addr: hrdata <= {16'h0000, break_data_high, break_data_low};
            hbc_pkg::stat_byte_addr: hrdata <= {29'h0, pending_boundary,
                                                software_interrupt_req, debug_halt_mode_req};
            default:                 hrdata <= 32'h0000_0000;
         endcase
      end
   end

   assign mode = hbc_pkg::hbc_mode_t'({breakpoint_control_zero[hbc_pkg::ctl0_mode_hi_pos],
                                      breakpoint_control_zero[hbc_pkg::ctl0_mode_lo_pos]});
   assign program_only_break       = breakpoint_control_zero[hbc_pkg::ctl0_prog_only_pos];
   assign second_range_full        = breakpoint_control_zero[hbc_pkg::ctl0_range1_pos];
   assign first_range_full         = breakpoint_control_zero[hbc_pkg::ctl0_range0_pos];
   assign data_reg_compare_enable  = breakpoint_control_one[hbc_pkg::ctl1_data_en_pos];
   assign high_byte_mask           = breakpoint_control_one[hbc_pkg::ctl1_mask_hi_pos];
   assign low_byte_mask            = breakpoint_control_one[hbc_pkg::ctl1_mask_lo_pos];
   assign second_rw_qualify_enable = breakpoint_control_one[hbc_pkg::ctl1_rw1_en_pos];
   assign second_rw_value          = breakpoint_control_one[hbc_pkg::ctl1_rw1_val_pos];
   assign first_rw_qualify_enable  = breakpoint_control_one[hbc_pkg::ctl1_rw0_en_pos];
   assign first_rw_value           = breakpoint_control_one[hbc_pkg::ctl1_rw0_val_pos];

   // Interrupt mode always uses program breakpoints, whatever the program-only bit says.
   assign prog_mode = (mode == hbc_pkg::hbc_mode_irq_dual) || program_only_break;

   // Breakpoint 0: address registers against the address bus.
   hbc_byte_cmp u_bp0 (
      .ref_value ({break_addr_high, break_addr_low}),
      .bus_value (cpu_addr),
      .use_high  (1'b1),
      .use_low   (first_range_full),
      .match     (bp0_addr_hit)
   );

   // Breakpoint 1: data registers against the address bus in dual modes.
   hbc_byte_cmp u_bp1 (
      .ref_value ({break_data_high, break_data_low}),
      .bus_value (cpu_addr),
      .use_high  (1'b1),
      .use_low   (second_range_full),
      .match     (bp1_addr_hit)
   );

   // Full mode data compare; only active with data enable and program-only clear.
   assign full_data_on  = data_reg_compare_enable && !program_only_break;
   assign data_use_high = full_data_on && !high_byte_mask;
   assign data_use_low  = full_data_on && !low_byte_mask;

   hbc_byte_cmp u_data (
      .ref_value ({break_data_high, break_data_low}),
      .bus_value (cpu_data),
      .use_high  (data_use_high),
      .use_low   (data_use_low),
      .match     (data_hit)
   );

   // Read/write qualification is dropped for program breakpoints and interrupt mode.
   assign bp0_use_rw = first_rw_qualify_enable && !prog_mode;
   assign bp1_use_rw = second_rw_qualify_enable && !prog_mode
                       && (mode == hbc_pkg::hbc_mode_halt_dual);

   assign bp0_hit = bp0_addr_hit
                    && (!bp0_use_rw || (cpu_read == first_rw_value));
   assign bp1_hit = data_reg_compare_enable && bp1_addr_hit
                    && (!bp1_use_rw || (cpu_read == second_rw_value));

   always_comb begin
      unique case (mode)
         hbc_pkg::hbc_mode_off:      raw_match = 1'b0;
         hbc_pkg::hbc_mode_irq_dual:  raw_match = bp0_hit || bp1_hit;
         hbc_pkg::hbc_mode_halt_full: raw_match = bp0_hit && data_hit;
         hbc_pkg::hbc_mode_halt_dual: raw_match = bp0_hit || bp1_hit;
      endcase
   end

   assign halt_allowed = debug_halt_mode_enabled && !debug_halt_mode_active;

   // Program breakpoints tag the matching fetch; data/unexecuted opcodes never break.
   assign fetch_tag = cpu_cycle_valid && cpu_fetch && prog_mode && raw_match
                      && !debug_halt_mode_active;

   // Immediate breakpoints wait for the next instruction boundary.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_boundary <= 1'b0;
      end else if (debug_halt_mode_active || mode == hbc_pkg::hbc_mode_off) begin
         pending_boundary <= 1'b0;
      end else if (cpu_cycle_valid && !prog_mode && raw_match) begin
         pending_boundary <= 1'b1;
      end else if (cpu_boundary) begin
         pending_boundary <= 1'b0;
      end
   end

   // Requests are one-cycle pulses toward the CPU.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         software_interrupt_req <= 1'b0;
         debug_halt_mode_req    <= 1'b0;
      end else begin
         software_interrupt_req <= (mode == hbc_pkg::hbc_mode_irq_dual) && cpu_exec_valid
                                   && cpu_exec_tag && !debug_halt_mode_active;
         debug_halt_mode_req    <= halt_allowed && (mode != hbc_pkg::hbc_mode_irq_dual)
                                   && (mode != hbc_pkg::hbc_mode_off)
                                   && ((pending_boundary && cpu_boundary)
                                       || (prog_mode && cpu_exec_valid
                                           && cpu_exec_tag));
      end
   end

endmodule : hbc_top

// *** hbc_top_props.sv ***
`timescale 1ns/1ps
// Concurrent checks on the breakpoint comparator ports.
module hbc_top_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cpu_cycle_valid,
   input wire logic cpu_fetch,
   input wire logic cpu_exec_valid,
   input wire logic cpu_exec_tag,
   input wire logic cpu_boundary,
   input wire logic debug_halt_mode_active,
   input wire logic debug_halt_mode_enabled,
   input wire logic fetch_tag,
   input wire logic software_interrupt_req,
   input wire logic debug_halt_mode_req
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_bus_no_wait: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_irq_pulse: assert property (software_interrupt_req |=> !software_interrupt_req)
      else $error("interrupt request too long");
   a_halt_pulse: assert property (debug_halt_mode_req |=> !debug_halt_mode_req)
      else $error("halt request too long");
   a_irq_from_exec: assert property (software_interrupt_req |->
      $past(cpu_exec_valid && cpu_exec_tag))
      else $error("interrupt without tagged opcode");
   a_halt_needs_enable: assert property (debug_halt_mode_req |->
      $past(debug_halt_mode_enabled))
      else $error("halt while debug disabled");
   a_active_blocks: assert property ((software_interrupt_req || debug_halt_mode_req) |->
      !$past(debug_halt_mode_active))
      else $error("break while debug active");
   a_tag_on_fetch: assert property (fetch_tag |-> cpu_fetch && cpu_cycle_valid)
      else $error("tag on non fetch cycle");
   a_halt_timing: assert property (debug_halt_mode_req |->
      $past(cpu_boundary) || $past(cpu_exec_valid && cpu_exec_tag))
      else $error("halt off boundary");
   a_one_request: assert property (!(software_interrupt_req && debug_halt_mode_req))
      else $error("both requests at once");

   c_irq: cover property (software_interrupt_req);
   c_halt: cover property (debug_halt_mode_req);
   c_tag: cover property (fetch_tag);
endmodule : hbc_top_props

bind hbc_top hbc_top_props i_hbc_top_props (.hclk, .hresetn, .hreadyout, .hresp, .cpu_cycle_valid,
   .cpu_fetch, .cpu_exec_valid, .cpu_exec_tag, .cpu_boundary, .debug_halt_mode_active,
   .debug_halt_mode_enabled, .fetch_tag, .software_interrupt_req, .debug_halt_mode_req);

// *** tb_top.sv ***
`timescale 1ns/1ps
// Self-checking testbench for the breakpoint comparator.
module tb_top;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, fetch_tag, irq_req, halt_req;
   logic        cyc_v, rd, fe, ex_v, ex_t, bnd, active = 1'b0, enabled = 1'b1;
   logic [15:0] addr, data;
   int          error_cnt = 0, checks_done = 0, halt_cnt = 0, irq_cnt = 0;

   always #2 hclk = ~hclk;
   assign hready = hreadyout;
   always @(posedge hclk) begin
      if (halt_req === 1'b1) halt_cnt++;
      if (irq_req === 1'b1) irq_cnt++;
   end

   hbc_top i_hbc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
      .hreadyout, .hresp, .hrdata, .cpu_cycle_valid(cyc_v), .cpu_addr(addr), .cpu_data(data),
      .cpu_read(rd), .cpu_fetch(fe), .cpu_exec_valid(ex_v), .cpu_exec_tag(ex_t), .cpu_boundary(bnd),
      .debug_halt_mode_active(active), .debug_halt_mode_enabled(enabled), .fetch_tag,
      .software_interrupt_req(irq_req), .debug_halt_mode_req(halt_req));
   hbc_cpu_model i_hbc_cpu_model (.hclk, .fetch_tag, .cpu_cycle_valid(cyc_v), .cpu_addr(addr),
      .cpu_data(data), .cpu_read(rd), .cpu_fetch(fe), .cpu_exec_valid(ex_v), .cpu_exec_tag(ex_t),
      .cpu_boundary(bnd));

   task test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (n >= 16) begin
         error_cnt++;
         test_done();
      end
   endtask : wait_rdy

   // One single word transfer; read data is taken at the data phase edge.
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : ahb

   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask : wr

   // One CPU cycle, then the tagged opcode runs or a boundary passes; request counts are judged.
   task run(input logic [15:0] a, input logic [15:0] d, input logic r, input logic f,
            input logic tag_exp, input int dh, input int ds);
      int   h0, s0;
      logic tag;
      h0 = halt_cnt;
      s0 = irq_cnt;
      i_hbc_cpu_model.cycle(a, d, r, f, tag);
      check({31'h0, tag}, {31'h0, tag_exp});
      repeat (2) @(posedge hclk);
      if (tag === 1'b1) i_hbc_cpu_model.execute(1'b1);
      else i_hbc_cpu_model.boundary();
      repeat (3) @(posedge hclk);
      check(32'(halt_cnt - h0), 32'(dh));
      check(32'(irq_cnt - s0), 32'(ds));
   endtask : run

   task t_regs();
      logic [31:0] q;
      ahb(1'b0, hbc_pkg::ctl0_byte_addr, 32'h0, q);
      check(q, 32'h0);
      wr(hbc_pkg::ctl0_byte_addr, 32'hff);
      ahb(1'b0, hbc_pkg::ctl0_byte_addr, 32'h0, q);
      check(q, 32'he3);
      wr(hbc_pkg::ctl1_byte_addr, 32'hff);
      ahb(1'b0, hbc_pkg::ctl1_byte_addr, 32'h0, q);
      check(q, 32'hfe);
      wr(hbc_pkg::addr_byte_addr, 32'h1234_abcd);
      ahb(1'b0, hbc_pkg::addr_byte_addr, 32'h0, q);
      check(q, 32'h0000_abcd);
      ahb(1'b0, hbc_pkg::stat_byte_addr, 32'h0, q);
      check(q, 32'h0);
      ahb(1'b0, 32'h94, 32'h0, q);
      check(q, 32'h0);
   endtask : t_regs

   task t_full();
      wr(hbc_pkg::ctl0_byte_addr, 32'h80);
      wr(hbc_pkg::ctl1_byte_addr, 32'ha0);
      wr(hbc_pkg::addr_byte_addr, 32'haba0);
      wr(hbc_pkg::data_byte_addr, 32'h5500);
      run(16'hab34, 16'h55ff, 1'b1, 1'b0, 1'b0, 1, 0);
      run(16'hab34, 16'h56ff, 1'b1, 1'b0, 1'b0, 0, 0);
      run(16'hab77, 16'h5511, 1'b0, 1'b0, 1'b0, 1, 0);
      active <= 1'b1;
      run(16'hab34, 16'h55ff, 1'b1, 1'b0, 1'b0, 0, 0);
      active <= 1'b0;
   endtask : t_full

   task t_swi();
      wr(hbc_pkg::ctl0_byte_addr, 32'h40);
      wr(hbc_pkg::ctl1_byte_addr, 32'h80);
      wr(hbc_pkg::addr_byte_addr, 32'hc080);
      wr(hbc_pkg::data_byte_addr, 32'h7700);
      run(16'hc012, 16'h0, 1'b1, 1'b1, 1'b1, 0, 1);
      run(16'hc012, 16'h0, 1'b1, 1'b0, 1'b0, 0, 0);
      run(16'h7755, 16'h0, 1'b0, 1'b1, 1'b1, 0, 1);
      wr(hbc_pkg::ctl0_byte_addr, 32'h60);
      run(16'hc0ee, 16'h0, 1'b1, 1'b1, 1'b1, 0, 1);
      wr(hbc_pkg::ctl1_byte_addr, 32'h00);
      run(16'h7755, 16'h0, 1'b1, 1'b1, 1'b0, 0, 0);
   endtask : t_swi

   task t_dual();
      wr(hbc_pkg::ctl0_byte_addr, 32'hc0);
      wr(hbc_pkg::ctl1_byte_addr, 32'h06);
      wr(hbc_pkg::addr_byte_addr, 32'hd006);
      run(16'hd011, 16'h0, 1'b0, 1'b0, 1'b0, 0, 0);
      run(16'hd011, 16'h0, 1'b1, 1'b0, 1'b0, 1, 0);
      enabled <= 1'b0;
      run(16'hd011, 16'h0, 1'b1, 1'b0, 1'b0, 0, 0);
      enabled <= 1'b1;
      wr(hbc_pkg::ctl0_byte_addr, 32'h00);
      run(16'hd011, 16'h0, 1'b1, 1'b0, 1'b0, 0, 0);
   endtask : t_dual

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_full();
      t_swi();
      t_dual();
      test_done();
   end
endmodule : tb_top
